// [pkg/io_defs.svh]
// Offsets, field positions, reset values and timing counts of the I/O block
//
// Summary of operation
// R1: Enabled filter holds state until a new level lasts the set time.
// R2: Separate high and low counts, 2 to 65535 ticks of 5 ms.
// R3: Selected inputs matching a preset pattern raise a request.
// R4: A change on a monitored input raises a request.
// R5: Each input feeds a 16-bit counter, plus one per counted edge.
// R6: Counters count inputs up to 500 Hz with 1 ms levels.
// R7: Counter overflow and counter match each raise a request.
// R8: Each PWM output stays high for 1 to 65535 steps of 100 us.
// R9: Each PWM output stays low for its own 1 to 65535 steps.
// R10: Eight software relays, each with a state indicator.
// R11: Jumper picks relay clear on every bus reset or power-on only.
// R12: After power loss all relays start off.
// R13: Read-identifier command 0x0d returns the board identifier.
// R14: Identifier is four switch bits, position 1 most significant.
// R15: Filtering enabled per input.
// R16: Each counter counts rising or falling edges.
// R17: Counter starts at a set value and reloads it after overflow.
// R18: Change request on rising, falling or both edges.
// R19: Inputs outside the pattern mask never affect the match.
// R20: Flags hold until cleared; request stays while an enabled flag is set.
// R21: PWM alternates high and low periods continuously once started.
`ifndef IO_DEFS_SVH
`define IO_DEFS_SVH

`define CLK_MHZ          100
`define FILT_TICK_MS     5
`define PWM_STEP_US      100
`define FILT_TICK_CYCLES (`FILT_TICK_MS * 1000 * `CLK_MHZ)
`define PWM_STEP_CYCLES  (`PWM_STEP_US * `CLK_MHZ)

`define CMD_READ_ID      16'h000d
`define FILT_QUAL_RST    16'h0002
`define PWM_PERIOD_RST   16'h0001

`define REG_RELAY        7'h00
`define REG_DI_STATE     7'h01
`define REG_FILT_EN      7'h02
`define REG_PM_MASK      7'h03
`define REG_PM_VALUE     7'h04
`define REG_COS_RISE     7'h05
`define REG_COS_FALL     7'h06
`define REG_CTR_EN       7'h07
`define REG_CTR_FALL     7'h08
`define REG_IE_CMATCH    7'h09
`define REG_IE_COVF      7'h0a
`define REG_IE_PMCOS     7'h0b
`define REG_ST_CMATCH    7'h0c
`define REG_ST_COVF      7'h0d
`define REG_ST_PMCOS     7'h0e
`define REG_CMD          7'h0f
`define REG_CMD_RESP     7'h10
`define REG_PWM_CTRL     7'h11
`define REG_PWM_BASE     7'h12
`define REG_FILT_HI      7'h20
`define REG_FILT_LO      7'h28
`define REG_CTR_RST      7'h30
`define REG_CTR_MATCH    7'h38
`define REG_CTR_VAL      7'h40

`define PMCOS_PM_BIT     8

`endif

// [pkg/io_pkg.sv]
// Shared types of the isolated input, relay and pulse output block
package io_pkg;

  typedef logic [15:0] word_t;

  typedef enum logic [2:0] {
    PULSE_IDLE = 3'b001,
    PULSE_HIGH = 3'b010,
    PULSE_LOW  = 3'b100
  } pulse_state_e;

endpackage : io_pkg

// [logic/input_channel.sv]
// One isolated input: pin synchroniser, level filter and edge detect
`timescale 1ns/1ns
module input_channel (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Pin and filter timing
  input  wire logic        raw_i,
  input  wire logic        tick_i,
  // Configuration
  input  wire logic        filt_en_i,
  input  wire logic [15:0] qual_hi_i,
  input  wire logic [15:0] qual_lo_i,
  // Qualified state and its edges
  output logic             state_o,
  output logic             rise_o,
  output logic             fall_o
);

  logic [2:0]  sync;
  logic        level;
  logic [15:0] run;
  logic [15:0] need;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync  <= 3'h0;
      level <= 1'b0;
    end else begin
      sync <= {sync[1:0], raw_i};
      // Only a value seen equal on the last two stages counts
      if (sync[1] == sync[2]) begin
        level <= sync[2];
      end
    end
  end

  assign need = level ? qual_hi_i : qual_lo_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_o <= 1'b0;
      run     <= 16'h0000;
    end else if (!filt_en_i) begin
      state_o <= level;                                  // [R15]
      run     <= 16'h0000;
    end else if (level == state_o) begin
      run <= 16'h0000;
    end else if (tick_i) begin
      // Partial first tick adds up to one extra tick of latency
      if (run >= need) begin
        state_o <= level;                                // [R1] [R2]
        run     <= 16'h0000;
      end else begin
        run <= run + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      if (filt_en_i ? (tick_i && run >= need && level != state_o)
                    : (level != state_o)) begin
        rise_o <= level;
        fall_o <= !level;
      end
    end
  end

endmodule : input_channel

// [logic/pulse_gen.sv]
// One pulse output alternating programmed high and low periods
`timescale 1ns/1ns
module pulse_gen (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Step timing and configuration
  input  wire logic        step_i,
  input  wire logic        run_i,
  input  wire logic [15:0] high_steps_i,
  input  wire logic [15:0] low_steps_i,
  // Pin
  output logic             pulse_o
);

  io_pkg::pulse_state_e state;
  logic [15:0]          left;

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      state   <= io_pkg::PULSE_IDLE;
      pulse_o <= 1'b0;
      left    <= 16'h0000;
    end else begin
      case (state)
        io_pkg::PULSE_IDLE: begin
          state   <= io_pkg::PULSE_HIGH;
          pulse_o <= 1'b1;
          left    <= high_steps_i;
        end
        io_pkg::PULSE_HIGH: begin
          if (step_i) begin
            if (left <= 16'h0001) begin
              state   <= io_pkg::PULSE_LOW;                // [R8] [R21]
              pulse_o <= 1'b0;
              left    <= low_steps_i;
            end else begin
              left <= left - 16'h0001;
            end
          end
        end
        io_pkg::PULSE_LOW: begin
          if (step_i) begin
            if (left <= 16'h0001) begin
              state   <= io_pkg::PULSE_HIGH;               // [R9] [R21]
              pulse_o <= 1'b1;
              left    <= high_steps_i;
            end else begin
              left <= left - 16'h0001;
            end
          end
        end
        default: begin
          state   <= io_pkg::PULSE_IDLE;
          pulse_o <= 1'b0;
        end
      endcase
    end
  end

endmodule : pulse_gen

// [logic/isolated_io.sv]
// Top of the isolated input, relay and pulse output block
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "io_defs.svh"
module isolated_io #(
  parameter int FILT_TICK_CYCLES = `FILT_TICK_CYCLES,
  parameter int PWM_STEP_CYCLES  = `PWM_STEP_CYCLES,
  parameter int CHANNELS         = 8,
  parameter int PULSES           = 2
) (
  // Clock and power-on reset
  input  wire logic                MCLK_I,
  input  wire logic                RST_I,
  // Register port
  input  wire logic [6:0]          ADDR_I,
  input  wire logic [15:0]         WDATA_I,
  input  wire logic                WR_I,
  input  wire logic                RD_I,
  output logic      [15:0]         RDATA_O,
  // Interrupt request
  output logic                     IRQ_O,
  // Bus reset pin and board straps
  input  wire logic                BUS_RST_I,
  input  wire logic                RELAY_CLEAR_SOURCE_JUMPER_I,
  input  wire logic [3:0]          BOARD_IDENTIFIER_SWITCH_I,
  // Isolated inputs
  input  wire logic [CHANNELS-1:0] ISOLATED_INPUT_CHANNEL_I,
  // Relays and their indicators
  output logic      [CHANNELS-1:0] RELAY_CHANNEL_O,
  output logic      [CHANNELS-1:0] RELAY_LED_O,
  // Pulse outputs
  output logic      [PULSES-1:0]   PULSE_OUTPUT_CHANNEL_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Flag update where a new event beats a clear in the same cycle

  function automatic logic [15:0] flag_update(input logic [15:0] cur,
                                              input logic [15:0] set,
                                              input logic [15:0] clr);
    flag_update = (cur & ~clr) | set;
  endfunction : flag_update

  function automatic logic [15:0] pad8(input logic [CHANNELS-1:0] v);
    pad8 = 16'(v);
  endfunction : pad8

  ////////////////////////////////////////////////////////////////////////////
  // Timebases

  logic [31:0] filt_cnt;
  logic [31:0] step_cnt;
  logic        filt_tick;
  logic        pwm_step;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      filt_cnt  <= 32'h0;
      filt_tick <= 1'b0;
    end else if (filt_cnt == 32'(FILT_TICK_CYCLES - 1)) begin
      filt_cnt  <= 32'h0;
      filt_tick <= 1'b1;
    end else begin
      filt_cnt  <= filt_cnt + 32'h1;
      filt_tick <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      step_cnt <= 32'h0;
      pwm_step <= 1'b0;
    end else if (step_cnt == 32'(PWM_STEP_CYCLES - 1)) begin
      step_cnt <= 32'h0;
      pwm_step <= 1'b1;
    end else begin
      step_cnt <= step_cnt + 32'h1;
      pwm_step <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [CHANNELS-1:0] filt_en;
  logic [CHANNELS-1:0] pm_mask;
  logic [CHANNELS-1:0] pm_value;
  logic [CHANNELS-1:0] cos_rise;
  logic [CHANNELS-1:0] cos_fall;
  logic [CHANNELS-1:0] ctr_en;
  logic [CHANNELS-1:0] ctr_fall;
  logic [CHANNELS-1:0] ie_cmatch;
  logic [CHANNELS-1:0] ie_covf;
  logic [CHANNELS:0]   ie_pmcos;
  logic [PULSES-1:0]   pwm_run;
  logic [3:0]          cmd_resp;
  io_pkg::word_t       filt_hi   [CHANNELS];
  io_pkg::word_t       filt_lo   [CHANNELS];
  io_pkg::word_t       ctr_rst   [CHANNELS];
  io_pkg::word_t       ctr_match [CHANNELS];
  io_pkg::word_t       pwm_hi    [PULSES];
  io_pkg::word_t       pwm_lo    [PULSES];
  logic [3:0]          id_sync [3];

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      filt_en   <= '0;
      pm_mask   <= '0;
      pm_value  <= '0;
      cos_rise  <= '0;
      cos_fall  <= '0;
      ctr_en    <= '0;
      ctr_fall  <= '0;
      ie_cmatch <= '0;
      ie_covf   <= '0;
      ie_pmcos  <= '0;
      pwm_run   <= '0;
    end else if (WR_I) begin
      case (ADDR_I)
        `REG_FILT_EN:   filt_en   <= WDATA_I[CHANNELS-1:0];
        `REG_PM_MASK:   pm_mask   <= WDATA_I[CHANNELS-1:0];
        `REG_PM_VALUE:  pm_value  <= WDATA_I[CHANNELS-1:0];
        `REG_COS_RISE:  cos_rise  <= WDATA_I[CHANNELS-1:0];
        `REG_COS_FALL:  cos_fall  <= WDATA_I[CHANNELS-1:0];
        `REG_CTR_EN:    ctr_en    <= WDATA_I[CHANNELS-1:0];
        `REG_CTR_FALL:  ctr_fall  <= WDATA_I[CHANNELS-1:0];
        `REG_IE_CMATCH: ie_cmatch <= WDATA_I[CHANNELS-1:0];
        `REG_IE_COVF:   ie_covf   <= WDATA_I[CHANNELS-1:0];
        `REG_IE_PMCOS:  ie_pmcos  <= WDATA_I[CHANNELS:0];
        `REG_PWM_CTRL:  pwm_run   <= WDATA_I[PULSES-1:0];
        default: ;
      endcase
    end
  end

  // Per-channel and per-output word tables
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < CHANNELS; i++) begin
        filt_hi[i]   <= `FILT_QUAL_RST;
        filt_lo[i]   <= `FILT_QUAL_RST;
        ctr_rst[i]   <= 16'h0000;
        ctr_match[i] <= 16'hffff;
      end
      for (int p = 0; p < PULSES; p++) begin
        pwm_hi[p] <= `PWM_PERIOD_RST;
        pwm_lo[p] <= `PWM_PERIOD_RST;
      end
    end else if (WR_I) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (ADDR_I == `REG_FILT_HI + 7'(i))
          filt_hi[i] <= WDATA_I;                          // [R2]
        if (ADDR_I == `REG_FILT_LO + 7'(i))
          filt_lo[i] <= WDATA_I;                          // [R2]
        if (ADDR_I == `REG_CTR_RST + 7'(i))
          ctr_rst[i] <= WDATA_I;
        if (ADDR_I == `REG_CTR_MATCH + 7'(i))
          ctr_match[i] <= WDATA_I;
      end
      for (int p = 0; p < PULSES; p++) begin
        if (ADDR_I == `REG_PWM_BASE + 7'(2 * p))
          pwm_hi[p] <= WDATA_I;
        if (ADDR_I == `REG_PWM_BASE + 7'(2 * p + 1))
          pwm_lo[p] <= WDATA_I;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Board identifier and read-identifier command

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      id_sync[0] <= 4'h0;
      id_sync[1] <= 4'h0;
      id_sync[2] <= 4'h0;
    end else begin
      id_sync[0] <= BOARD_IDENTIFIER_SWITCH_I;
      id_sync[1] <= id_sync[0];
      id_sync[2] <= id_sync[1];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      cmd_resp <= 4'h0;
    end else if (WR_I && ADDR_I == `REG_CMD && WDATA_I == `CMD_READ_ID &&
                 id_sync[1] == id_sync[2]) begin
      // Port bit 3 is switch position 1, bit 0 is position 4
      cmd_resp <= id_sync[2];                             // [R13] [R14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Relays with selectable bus-reset clearing

  logic [2:0] bus_rst_sync;
  logic [2:0] jumper_sync;
  logic       bus_rst;
  logic       clear_on_bus;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      bus_rst_sync <= 3'h0;
      jumper_sync  <= 3'h0;
      bus_rst      <= 1'b0;
      clear_on_bus <= 1'b0;
    end else begin
      bus_rst_sync <= {bus_rst_sync[1:0], BUS_RST_I};
      jumper_sync  <= {jumper_sync[1:0], RELAY_CLEAR_SOURCE_JUMPER_I};
      if (bus_rst_sync[1] == bus_rst_sync[2])
        bus_rst <= bus_rst_sync[2];
      if (jumper_sync[1] == jumper_sync[2])
        clear_on_bus <= jumper_sync[2];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      RELAY_CHANNEL_O <= '0;                              // [R12]
      RELAY_LED_O     <= '0;
    end else if (bus_rst && clear_on_bus) begin
      RELAY_CHANNEL_O <= '0;                              // [R11]
      RELAY_LED_O     <= '0;
    end else if (WR_I && ADDR_I == `REG_RELAY) begin
      RELAY_CHANNEL_O <= WDATA_I[CHANNELS-1:0];           // [R10]
      RELAY_LED_O     <= WDATA_I[CHANNELS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input channels

  logic [CHANNELS-1:0] di_state;
  logic [CHANNELS-1:0] di_rise;
  logic [CHANNELS-1:0] di_fall;

  for (genvar g = 0; g < CHANNELS; g++) begin : gen_in
    input_channel u_in (
      .clk_i     (MCLK_I),
      .rst_i     (RST_I),
      .raw_i     (ISOLATED_INPUT_CHANNEL_I[g]),
      .tick_i    (filt_tick),
      .filt_en_i (filt_en[g]),
      .qual_hi_i (filt_hi[g]),
      .qual_lo_i (filt_lo[g]),
      .state_o   (di_state[g]),
      .rise_o    (di_rise[g]),
      .fall_o    (di_fall[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event counters

  io_pkg::word_t       ctr [CHANNELS];
  logic [CHANNELS-1:0] ctr_hit;
  logic [CHANNELS-1:0] ctr_wrap;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < CHANNELS; i++)
        ctr[i] <= 16'h0000;
      ctr_hit  <= '0;
      ctr_wrap <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        ctr_hit[i]  <= 1'b0;
        ctr_wrap[i] <= 1'b0;
        if (!ctr_en[i]) begin
          // Idle counters sit at their start value, ready to run
          ctr[i] <= ctr_rst[i];
        end else if (ctr_fall[i] ? di_fall[i] : di_rise[i]) begin // [R16]
          if (ctr[i] == 16'hffff) begin
            ctr[i]      <= ctr_rst[i];                    // [R17]
            ctr_wrap[i] <= 1'b1;                          // [R7]
          end else begin
            ctr[i]     <= ctr[i] + 16'h0001;              // [R5] [R6]
            ctr_hit[i] <= (ctr[i] + 16'h0001) == ctr_match[i]; // [R7]
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pattern match and change of state

  logic pm_now;
  logic pm_last;
  logic pm_event;
  logic [CHANNELS-1:0] cos_event;

  // An empty mask never matches, so it cannot fire on its own
  assign pm_now = (pm_mask != '0) &&
                  (((di_state ^ pm_value) & pm_mask) == '0); // [R3] [R19]

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      pm_last   <= 1'b0;
      pm_event  <= 1'b0;
      cos_event <= '0;
    end else begin
      pm_last   <= pm_now;
      pm_event  <= pm_now && !pm_last;                    // [R3]
      cos_event <= (di_rise & cos_rise) | (di_fall & cos_fall); // [R4] [R18]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags and interrupt request

  logic [CHANNELS-1:0] st_cmatch;
  logic [CHANNELS-1:0] st_covf;
  logic [CHANNELS:0]   st_pmcos;
  logic [15:0]         clr_cmatch;
  logic [15:0]         clr_covf;
  logic [15:0]         clr_pmcos;
  logic [15:0]         next_pmcos;

  assign clr_cmatch = (WR_I && ADDR_I == `REG_ST_CMATCH) ? WDATA_I : 16'h0;
  assign clr_covf   = (WR_I && ADDR_I == `REG_ST_COVF)   ? WDATA_I : 16'h0;
  assign clr_pmcos  = (WR_I && ADDR_I == `REG_ST_PMCOS)  ? WDATA_I : 16'h0;
  assign next_pmcos = flag_update(16'(st_pmcos),
                                  16'({pm_event, cos_event}), clr_pmcos);

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      st_cmatch <= '0;
      st_covf   <= '0;
      st_pmcos  <= '0;
    end else begin
      st_cmatch <= CHANNELS'(flag_update(pad8(st_cmatch), pad8(ctr_hit),
                                         clr_cmatch));   // [R20]
      st_covf   <= CHANNELS'(flag_update(pad8(st_covf), pad8(ctr_wrap),
                                         clr_covf));     // [R20]
      st_pmcos  <= next_pmcos[CHANNELS:0];               // [R20]
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I)
      IRQ_O <= 1'b0;
    else
      IRQ_O <= |(st_cmatch & ie_cmatch) | |(st_covf & ie_covf) |
               |(st_pmcos & ie_pmcos);                    // [R20]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse outputs

  for (genvar p = 0; p < PULSES; p++) begin : gen_pwm
    pulse_gen u_pwm (
      .clk_i        (MCLK_I),
      .rst_i        (RST_I),
      .step_i       (pwm_step),
      .run_i        (pwm_run[p]),
      .high_steps_i (pwm_hi[p]),
      .low_steps_i  (pwm_lo[p]),
      .pulse_o      (PULSE_OUTPUT_CHANNEL_O[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data stands in the cycle after the strobe only

  io_pkg::word_t next_rdata;

  always_comb begin
    next_rdata = 16'h0000;
    case (ADDR_I)
      `REG_RELAY:     next_rdata = pad8(RELAY_CHANNEL_O);
      `REG_DI_STATE:  next_rdata = pad8(di_state);
      `REG_FILT_EN:   next_rdata = pad8(filt_en);
      `REG_PM_MASK:   next_rdata = pad8(pm_mask);
      `REG_PM_VALUE:  next_rdata = pad8(pm_value);
      `REG_COS_RISE:  next_rdata = pad8(cos_rise);
      `REG_COS_FALL:  next_rdata = pad8(cos_fall);
      `REG_CTR_EN:    next_rdata = pad8(ctr_en);
      `REG_CTR_FALL:  next_rdata = pad8(ctr_fall);
      `REG_IE_CMATCH: next_rdata = pad8(ie_cmatch);
      `REG_IE_COVF:   next_rdata = pad8(ie_covf);
      `REG_IE_PMCOS:  next_rdata = 16'(ie_pmcos);
      `REG_ST_CMATCH: next_rdata = pad8(st_cmatch);
      `REG_ST_COVF:   next_rdata = pad8(st_covf);
      `REG_ST_PMCOS:  next_rdata = 16'(st_pmcos);
      `REG_CMD_RESP:  next_rdata = 16'(cmd_resp);
      `REG_PWM_CTRL:  next_rdata = 16'(pwm_run);
      default: begin
        for (int i = 0; i < CHANNELS; i++) begin
          if (ADDR_I == `REG_FILT_HI + 7'(i))   next_rdata = filt_hi[i];
          if (ADDR_I == `REG_FILT_LO + 7'(i))   next_rdata = filt_lo[i];
          if (ADDR_I == `REG_CTR_RST + 7'(i))   next_rdata = ctr_rst[i];
          if (ADDR_I == `REG_CTR_MATCH + 7'(i)) next_rdata = ctr_match[i];
          if (ADDR_I == `REG_CTR_VAL + 7'(i))   next_rdata = ctr[i];
        end
        for (int p = 0; p < PULSES; p++) begin
          if (ADDR_I == `REG_PWM_BASE + 7'(2 * p))     next_rdata = pwm_hi[p];
          if (ADDR_I == `REG_PWM_BASE + 7'(2 * p + 1)) next_rdata = pwm_lo[p];
        end
      end
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I)
      RDATA_O <= 16'h0000;
    else if (RD_I)
      RDATA_O <= next_rdata;
    else
      RDATA_O <= 16'h0000;
  end

endmodule : isolated_io

// [bench/io_chk.sv]
// Concurrent checks on the ports of the isolated I/O top
`timescale 1ns/1ns
module io_chk #(
  parameter int CHANNELS = 8,
  parameter int PULSES   = 2
) (
  // Clock, reset and register port
  input wire logic                MCLK_I,
  input wire logic                RST_I,
  input wire logic [6:0]          ADDR_I,
  input wire logic [15:0]         WDATA_I,
  input wire logic                WR_I,
  input wire logic                RD_I,
  input wire logic [15:0]         RDATA_O,
  input wire logic                IRQ_O,
  // Straps and outputs
  input wire logic                BUS_RST_I,
  input wire logic                RELAY_CLEAR_SOURCE_JUMPER_I,
  input wire logic [3:0]          BOARD_IDENTIFIER_SWITCH_I,
  input wire logic [CHANNELS-1:0] RELAY_CHANNEL_O,
  input wire logic [CHANNELS-1:0] RELAY_LED_O,
  input wire logic [PULSES-1:0]   PULSE_OUTPUT_CHANNEL_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  sequence relay_wr;
    WR_I && ADDR_I == 7'h00;
  endsequence
  sequence id_cmd;
    WR_I && ADDR_I == 7'h0f && WDATA_I == 16'h000d ##1 RD_I && ADDR_I == 7'h10;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_led_shows_relay: assert property (RELAY_LED_O == RELAY_CHANNEL_O)
    else $error("relay indicator differs from relay");
  a_relay_takes_write: assert property (relay_wr |=>
    RELAY_CHANNEL_O == $past(WDATA_I[CHANNELS-1:0]))
    else $error("relay did not take written value");
  a_relay_keeps_state: assert property (!RELAY_CLEAR_SOURCE_JUMPER_I &&
    !$past(WR_I) |-> $stable(RELAY_CHANNEL_O))
    else $error("relay changed without a write");
  a_bus_reset_clears: assert property ($rose(BUS_RST_I) &&
    RELAY_CLEAR_SOURCE_JUMPER_I |-> ##[1:8] RELAY_CHANNEL_O == '0)
    else $error("bus reset left relays on");
  a_power_on_off: assert property ($fell(RST_I) |-> RELAY_CHANNEL_O == '0 &&
    PULSE_OUTPUT_CHANNEL_O == '0 && !IRQ_O)
    else $error("outputs active after power-on reset");
  a_rdata_one_cycle: assert property (!RD_I |=> RDATA_O == 16'h0000)
    else $error("read data outside its cycle");
  a_id_answer: assert property (id_cmd |=>
    RDATA_O == {12'h000, BOARD_IDENTIFIER_SWITCH_I})
    else $error("identifier answer wrong");
  a_irq_held: assert property ($fell(IRQ_O) |-> $past(WR_I) || $past(WR_I, 2))
    else $error("interrupt dropped without acknowledge");
endmodule : io_chk

// [bench/host_bus.sv]
// Host model driving the register port one strobe per cycle
`timescale 1ns/1ns
module host_bus (
  // Clock and register port
  input  wire logic        clk_i,
  output logic      [6:0]  addr_o,
  output logic      [15:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o,
  input  wire logic [15:0] rdata_i
);
  // The next call lowers a write strobe, so none is assigned twice a step
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    addr_o <= a;
    wr_o <= 1'b0;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(posedge clk_i);
    d = rdata_i;
  endtask : rd
  task automatic idle(input int n);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask : idle
endmodule : host_bus

// [bench/tb.sv]
// Self-checking bench of the isolated I/O block
`timescale 1ns/1ns
module tb;
  logic        clk, rst, bus_rst, jumper, wr, rd, irq;
  logic [3:0]  sw;
  logic [7:0]  din, relay, led;
  logic [1:0]  pulse;
  logic [6:0]  addr;
  logic [15:0] wdata, rdata, d, q;
  int          err_count, total_checks, seed, c;
  isolated_io #(.FILT_TICK_CYCLES(20), .PWM_STEP_CYCLES(10)) u_dut (
    .MCLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq), .BUS_RST_I(bus_rst),
    .RELAY_CLEAR_SOURCE_JUMPER_I(jumper), .BOARD_IDENTIFIER_SWITCH_I(sw),
    .ISOLATED_INPUT_CHANNEL_I(din), .RELAY_CHANNEL_O(relay),
    .RELAY_LED_O(led), .PULSE_OUTPUT_CHANNEL_O(pulse));
  host_bus u_host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
    .rd_o(rd), .rdata_i(rdata));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  // Channel 2 starts at fffe so each rising edge alternates match and wrap
  function automatic logic [15:0] exp_count(input int ch);
    if (ch == 2) return 16'hfffe;
    return ch[0] ? 16'h0003 : 16'h0004;
  endfunction : exp_count
  task automatic span(input logic lvl, output int n);
    n = 0;
    while (pulse[0] === lvl && n < 1000) begin
      @(posedge clk);
      n++;
    end
  endtask : span
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    err_count++;
    results();
  end
  initial begin
    seed = 84694;
    {rst, bus_rst, jumper, sw, din} = {1'b1, 14'h0000};
    u_host.idle(10);
    rst <= 1'b0;
    @(posedge clk);
    check(16'(relay), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      d = 16'($random(seed)) | 16'h0001;
      u_host.wr(7'h00, d);
      u_host.rd(7'h00, q);
      check(q, 16'(d[7:0]));
      check(16'(led), 16'(d[7:0]));
    end
    bus_rst <= 1'b1;
    u_host.idle(8);
    bus_rst <= 1'b0;
    u_host.idle(8);
    check(16'(relay), 16'(d[7:0]));
    jumper <= 1'b1;
    u_host.idle(8);
    bus_rst <= 1'b1;
    u_host.idle(8);
    bus_rst <= 1'b0;
    check(16'(relay), 16'h0000);
    sw <= 4'($random(seed));
    u_host.idle(8);
    u_host.wr(7'h0f, 16'h000d);
    u_host.rd(7'h10, q);
    check(q, 16'(sw));
    sw <= ~sw;
    u_host.idle(8);
    u_host.wr(7'h0f, 16'h000e);
    u_host.rd(7'h10, q);
    check(q, {12'h000, ~sw});
    u_host.rd(7'h7f, q);
    check(q, 16'h0000);
    u_host.rd(7'h27, q);
    check(q, 16'h0002);
    u_host.wr(7'h32, 16'hfffe);
    u_host.wr(7'h08, 16'h00aa);
    u_host.wr(7'h03, 16'h0002);
    u_host.wr(7'h04, 16'h0002);
    u_host.wr(7'h05, 16'h0001);
    u_host.wr(7'h06, 16'h0002);
    u_host.wr(7'h09, 16'h0004);
    u_host.wr(7'h0a, 16'h0004);
    u_host.wr(7'h0b, 16'h0100);
    u_host.wr(7'h07, 16'h00ff);
    for (int i = 0; i < 3; i++) begin
      din <= 8'hff;
      u_host.idle(8);
      din <= 8'h00;
      u_host.idle(8);
    end
    din <= 8'hff;
    u_host.idle(10);
    for (int i = 0; i < 8; i++) begin
      u_host.rd(7'(7'h40 + i), q);
      check(q, exp_count(i));
    end
    u_host.rd(7'h0c, q);
    check(q, 16'h0004);
    u_host.rd(7'h0d, q);
    check(q, 16'h0004);
    u_host.rd(7'h0e, q);
    check(q, 16'h0103);
    check(16'(irq), 16'h0001);
    u_host.wr(7'h0c, 16'hffff);
    u_host.wr(7'h0d, 16'hffff);
    u_host.wr(7'h0e, 16'hffff);
    u_host.idle(4);
    check(16'(irq), 16'h0000);
    u_host.wr(7'h2b, 16'h0004);
    u_host.wr(7'h02, 16'h0008);
    din <= 8'h00;
    u_host.idle(20);
    u_host.rd(7'h01, q);
    check(q, 16'h0008);
    u_host.idle(140);
    u_host.rd(7'h01, q);
    check(q, 16'h0000);
    u_host.wr(7'h12, 16'h0003);
    u_host.wr(7'h13, 16'h0002);
    u_host.wr(7'h11, 16'h0001);
    u_host.idle(1);
    span(1'b0, c);
    span(1'b1, c);
    for (int i = 0; i < 2; i++) begin
      span(1'b0, c);
      check(16'(c), 16'h0014);
      span(1'b1, c);
      check(16'(c), 16'h001e);
    end
    check(16'(pulse[1]), 16'h0000);
    u_host.wr(7'h11, 16'h0000);
    u_host.idle(2);
    check(16'(pulse), 16'h0000);
    results();
  end
endmodule : tb
bind isolated_io io_chk #(.CHANNELS(CHANNELS), .PULSES(PULSES)) u_chk (
  .MCLK_I(MCLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .IRQ_O(IRQ_O),
  .BUS_RST_I(BUS_RST_I),
  .RELAY_CLEAR_SOURCE_JUMPER_I(RELAY_CLEAR_SOURCE_JUMPER_I),
  .BOARD_IDENTIFIER_SWITCH_I(BOARD_IDENTIFIER_SWITCH_I),
  .RELAY_CHANNEL_O(RELAY_CHANNEL_O), .RELAY_LED_O(RELAY_LED_O),
  .PULSE_OUTPUT_CHANNEL_O(PULSE_OUTPUT_CHANNEL_O));
